// *** design/path_trigger_pkg.sv ***
// Operation
// RL1: Sixty-four paths; path 0 is homing
// RL2: Strobe rising edge launches selected path
// RL3: Stop input rising edge terminates path
// RL4: Homing input rising edge launches path 0
// RL5: Four event inputs, both edges launch
// RL6: Separate rise and fall path maps
// RL7: Software write launches path immediately
// RL8: Software read returns execution outcome
// RL9: Capture done with enable launches 50
// RL10: Cam disengage launches configured exit path
// RL11: Software limits suspended while homing
// RL12: Homing sets end position to index
// RL13: Motor brakes past index, coordinate exact
// RL14: Optional path runs after homing
// RL15: Done outputs set on homing completion
// RL16: Inputs sampled, edges become one pulse
package path_trigger_pkg;

	// ****************************************
	// Path numbering
	// ****************************************
	localparam int          PATH_COUNT   = 64;
	localparam int          PATH_W       = 6;
	localparam logic [5:0]  HOMING_PATH  = 6'h00;
	localparam logic [5:0]  CAPTURE_PATH = 6'h32;
	localparam int          EVENT_COUNT  = 4;
	localparam int          POS_W        = 32;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0]  SW_TRIGGER_ADDR    = 8'h00;
	localparam logic [7:0]  EVENT_RISE_ADDR    = 8'h04;
	localparam logic [7:0]  EVENT_FALL_ADDR    = 8'h08;
	localparam logic [7:0]  CAPTURE_CFG_ADDR   = 8'h0c;
	localparam logic [7:0]  CAM_CFG_ADDR       = 8'h10;
	localparam logic [7:0]  INDEX_COORD_ADDR   = 8'h14;
	localparam logic [7:0]  HOMING_CFG_ADDR    = 8'h18;
	localparam logic [7:0]  END_POSITION_ADDR  = 8'h1c;
	localparam logic [7:0]  IRQ_STATUS_ADDR    = 8'h20;
	localparam logic [7:0]  IRQ_MASK_ADDR      = 8'h24;
	localparam logic [7:0]  STATE_ADDR         = 8'h28;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int          CAPTURE_LAUNCH_BIT = 3;
	localparam int          HOMING_AUTO_BIT    = 8;
	localparam int          RESULT_LSB         = 8;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [31:0] EVENT_MAP_RESET    = 32'h0000_0000;
	localparam logic [31:0] CONFIG_RESET       = 32'h0000_0000;
	localparam logic [3:0]  IRQ_MASK_RESET     = 4'h0;

	// ****************************************
	// Outcome codes on software trigger read
	// ****************************************
	localparam logic [3:0]  RESULT_IDLE     = 4'h0;
	localparam logic [3:0]  RESULT_RUNNING  = 4'h1;
	localparam logic [3:0]  RESULT_DONE     = 4'h2;
	localparam logic [3:0]  RESULT_STOPPED  = 4'h3;

	// Interrupt bits: launch, done, homed, stopped
	localparam int          IRQ_W = 4;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_HOMING,
		ST_HOME_BRAKE
	} exec_e;

	typedef struct packed {
		logic             valid;
		logic [5:0]       path;
	} launch_s;

	typedef struct packed {
		logic             psel;
		logic             penable;
		logic             pwrite;
		logic [7:0]       paddr;
		logic [31:0]      pwdata;
	} apb_req_s;

endpackage

// *** design/edge_detect.sv ***
`timescale 1ns/100ps
module edge_detect
	import path_trigger_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             mclk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] level_in,
	output logic      [WIDTH-1:0] rise_out,
	output logic      [WIDTH-1:0] fall_out
);

	typedef struct packed {
		logic [WIDTH-1:0] sample;
		logic [WIDTH-1:0] prev;
	} edge_state_s;

	edge_state_s state;
	edge_state_s next_state;

	always_comb begin
		next_state        = state;
		next_state.sample = level_in;
		next_state.prev   = state.sample;
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign rise_out = state.sample & ~state.prev; // RL16
	assign fall_out = ~state.sample & state.prev; // RL16

endmodule

// *** design/launch_arbiter.sv ***
`timescale 1ns/100ps
module launch_arbiter
	import path_trigger_pkg::*;
#(
	parameter int SOURCES = 8
) (
	input  wire launch_s [SOURCES-1:0] request_in,
	output launch_s                    grant_out
);

	// Lowest index wins
	always_comb begin
		grant_out = '0;
		for (int i = SOURCES - 1; i >= 0; i--) begin
			if (request_in[i].valid) begin
				grant_out = request_in[i];
			end
		end
	end

endmodule

// *** design/motion_path_trigger_select.sv ***
`timescale 1ns/100ps
module motion_path_trigger_select
	import path_trigger_pkg::*;
(
	input  wire logic                   mclk_in,
	input  wire logic                   rst_in,
	input  wire logic                   psel_in,
	input  wire logic                   penable_in,
	input  wire logic                   pwrite_in,
	input  wire logic [7:0]             paddr_in,
	input  wire logic [31:0]            pwdata_in,
	output logic      [31:0]            prdata_out,
	output logic                        pready_out,
	output logic                        pslverr_out,
	input  wire logic [PATH_W-1:0]      path_select_in,
	input  wire logic                   path_trigger_strobe_in,
	input  wire logic                   motion_stop_input_in,
	input  wire logic                   homing_start_input_in,
	input  wire logic [EVENT_COUNT-1:0] event_inputs_in,
	input  wire logic                   capture_done_in,
	input  wire logic                   cam_disengage_in,
	input  wire logic                   index_pulse_in,
	input  wire logic                   motion_complete_in,
	output logic                        launch_valid_out,
	output logic      [PATH_W-1:0]      launch_path_out,
	output logic                        stop_request_out,
	output logic                        homing_active_out,
	output logic                        soft_limit_enable_out,
	output logic      [POS_W-1:0]       command_end_position_out,
	output logic                        command_done_output_out,
	output logic                        homing_done_output_out,
	output logic                        irq_out
);

	localparam int SOURCES = 7;

	typedef struct packed {
		exec_e            exec;
		logic [5:0]       current_path;
		logic [3:0]       result;
		logic [31:0]      rise_map;
		logic [31:0]      fall_map;
		logic [31:0]      capture_cfg;
		logic [31:0]      cam_cfg;
		logic [31:0]      index_coord;
		logic [31:0]      homing_cfg;
		logic [31:0]      end_position;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_mask;
		logic             sw_pending;
		logic [5:0]       sw_path;
		logic             launch_valid;
		logic [5:0]       launch_path;
		logic             stop_req;
		logic             cmd_done;
		logic             home_done;
		logic             index_seen;
		logic             after_home;
		logic [31:0]      prdata;
	} core_state_s;

	core_state_s state;
	core_state_s next_state;

	logic [EVENT_COUNT+5:0] edge_rise;
	logic [EVENT_COUNT+5:0] edge_fall;
	launch_s [SOURCES-1:0]  request;
	launch_s                grant;
	logic [5:0]             rise_path [EVENT_COUNT];
	logic [5:0]             fall_path [EVENT_COUNT];
	logic                   rise_hit;
	logic                   fall_hit;
	logic [5:0]             rise_sel;
	logic [5:0]             fall_sel;
	logic                   apb_write;
	logic                   apb_read;
	logic                   addr_ok;
	logic [IRQ_W-1:0]       irq_set;

	// ****************************************
	// Helpers
	// ****************************************
	// Six-bit path field of a packed map word
	function automatic logic [5:0] map_field(input logic [31:0] word, input int idx);
		map_field = word[idx*8 +: 6];
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		mapped = (addr[1:0] == 2'b00) && (addr <= STATE_ADDR);
	endfunction

	function automatic logic [31:0] trigger_word(input logic [3:0] res, input logic [5:0] path);
		trigger_word = {20'h0_0000, res, 2'b00, path};
	endfunction

	function automatic logic [31:0] flag_word(input core_state_s s);
		flag_word = {24'h00_0000, s.after_home, s.index_seen, s.home_done, s.cmd_done,
		             2'b00, s.exec};
	endfunction

	// ****************************************
	// Input edge detection
	// ****************************************
	edge_detect #(
		.WIDTH(EVENT_COUNT + 6)
	) u_edges (
		.mclk_in  (mclk_in),
		.rst_in   (rst_in),
		.level_in ({event_inputs_in, index_pulse_in, cam_disengage_in, capture_done_in,
		            homing_start_input_in, motion_stop_input_in, path_trigger_strobe_in}),
		.rise_out (edge_rise),
		.fall_out (edge_fall)
	);

	// ****************************************
	// Event path maps
	// ****************************************
	always_comb begin
		rise_hit = 1'b0;
		fall_hit = 1'b0;
		rise_sel = '0;
		fall_sel = '0;
		for (int i = EVENT_COUNT - 1; i >= 0; i--) begin
			rise_path[i] = map_field(state.rise_map, i); // RL6
			fall_path[i] = map_field(state.fall_map, i); // RL6
			if (edge_rise[6+i]) begin // RL5
				rise_hit = 1'b1;
				rise_sel = rise_path[i];
			end
			if (edge_fall[6+i]) begin // RL5
				fall_hit = 1'b1;
				fall_sel = fall_path[i];
			end
		end
	end

	// ****************************************
	// Launch sources, highest priority first
	// ****************************************
	always_comb begin
		request[0] = '{valid: edge_rise[2], path: HOMING_PATH}; // RL4
		request[1] = '{valid: state.sw_pending, path: state.sw_path}; // RL7
		request[2] = '{valid: edge_rise[0], path: path_select_in}; // RL2
		request[3] = '{valid: rise_hit, path: rise_sel};
		request[4] = '{valid: fall_hit, path: fall_sel};
		request[5] = '{valid: edge_rise[3] && state.capture_cfg[CAPTURE_LAUNCH_BIT],
		               path: CAPTURE_PATH}; // RL9
		request[6] = '{valid: edge_rise[4], path: state.cam_cfg[5:0]}; // RL10
	end

	launch_arbiter #(
		.SOURCES(SOURCES)
	) u_arb (
		.request_in (request),
		.grant_out  (grant)
	);

	// ****************************************
	// APB decode
	// ****************************************
	assign apb_write = psel_in && penable_in && pwrite_in;
	assign apb_read  = psel_in && penable_in && !pwrite_in;
	assign addr_ok   = mapped(paddr_in);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_state              = state;
		next_state.launch_valid = 1'b0;
		next_state.stop_req     = 1'b0;
		irq_set                 = '0;

		// ****************************************
		// Launch, stop and sequencing
		// ****************************************
		if (state.sw_pending) begin
			next_state.sw_pending = 1'b0;
		end

		if (edge_rise[1]) begin // RL3
			next_state.stop_req = 1'b1;
			if (state.exec != ST_IDLE) begin
				next_state.exec   = ST_IDLE;
				next_state.result = RESULT_STOPPED;
				next_state.cmd_done = 1'b1;
				irq_set[3]        = 1'b1;
			end
		end else if (grant.valid) begin
			next_state.launch_valid = 1'b1;
			next_state.launch_path  = grant.path;
			next_state.current_path = grant.path;
			next_state.result       = RESULT_RUNNING;
			next_state.cmd_done     = 1'b0;
			irq_set[0]              = 1'b1;
			next_state.after_home   = 1'b0;
			if (grant.path == HOMING_PATH) begin // RL1
				next_state.exec       = ST_HOMING;
				next_state.home_done  = 1'b0; // RL15
				next_state.index_seen = 1'b0;
			end else begin
				next_state.exec = ST_RUN;
			end
		end else begin
			// ****************************************
			// Run and homing progress
			// ****************************************
			unique case (state.exec)
				ST_IDLE: begin
				end
				ST_RUN: begin
					if (motion_complete_in) begin
						next_state.exec     = ST_IDLE;
						next_state.result   = RESULT_DONE;
						next_state.cmd_done = 1'b1;
						irq_set[1]          = 1'b1;
					end
				end
				ST_HOMING: begin
					if (edge_rise[5]) begin // RL12
						next_state.end_position = state.index_coord;
						next_state.index_seen   = 1'b1;
						next_state.exec         = ST_HOME_BRAKE;
					end
				end
				ST_HOME_BRAKE: begin
					// Coordinate fixed; stop point lands past index
					if (motion_complete_in) begin // RL13
						next_state.exec      = ST_IDLE;
						next_state.result    = RESULT_DONE;
						next_state.cmd_done  = 1'b1; // RL15
						next_state.home_done = 1'b1; // RL15
						irq_set[2]           = 1'b1;
						if (state.homing_cfg[HOMING_AUTO_BIT]) begin // RL14
							next_state.launch_valid = 1'b1;
							next_state.launch_path  = state.homing_cfg[5:0];
							next_state.current_path = state.homing_cfg[5:0];
							next_state.exec         = ST_RUN;
							next_state.result       = RESULT_RUNNING;
							// Homing completion stays reported
							next_state.after_home   = 1'b1;
						end
					end
				end
			endcase
		end

		// ****************************************
		// Register readback
		// ****************************************
		next_state.prdata = '0;
		if (apb_read && addr_ok) begin
			unique case (paddr_in)
				SW_TRIGGER_ADDR: begin
					next_state.prdata = trigger_word(state.result, state.current_path); // RL8
				end
				EVENT_RISE_ADDR:   next_state.prdata = state.rise_map;
				EVENT_FALL_ADDR:   next_state.prdata = state.fall_map;
				CAPTURE_CFG_ADDR:  next_state.prdata = state.capture_cfg;
				CAM_CFG_ADDR:      next_state.prdata = state.cam_cfg;
				INDEX_COORD_ADDR:  next_state.prdata = state.index_coord;
				HOMING_CFG_ADDR:   next_state.prdata = state.homing_cfg;
				END_POSITION_ADDR: next_state.prdata = state.end_position;
				IRQ_STATUS_ADDR:   next_state.prdata = {28'h000_0000, state.irq_status};
				IRQ_MASK_ADDR:     next_state.prdata = {28'h000_0000, state.irq_mask};
				STATE_ADDR:        next_state.prdata = flag_word(state);
				default:           next_state.prdata = '0;
			endcase
		end

		// ****************************************
		// Interrupt status
		// ****************************************
		// Read clears, new events win
		if (apb_read && paddr_in == IRQ_STATUS_ADDR) begin
			next_state.irq_status = irq_set;
		end else begin
			next_state.irq_status = state.irq_status | irq_set;
		end

		// ****************************************
		// Register writes
		// ****************************************
		if (apb_write && addr_ok) begin
			unique case (paddr_in)
				SW_TRIGGER_ADDR: begin
					next_state.sw_pending = 1'b1; // RL7
					next_state.sw_path    = pwdata_in[5:0];
				end
				EVENT_RISE_ADDR:  next_state.rise_map    = pwdata_in;
				EVENT_FALL_ADDR:  next_state.fall_map    = pwdata_in;
				CAPTURE_CFG_ADDR: next_state.capture_cfg = pwdata_in;
				CAM_CFG_ADDR:     next_state.cam_cfg     = pwdata_in;
				INDEX_COORD_ADDR: next_state.index_coord = pwdata_in;
				HOMING_CFG_ADDR:  next_state.homing_cfg  = pwdata_in;
				IRQ_MASK_ADDR:    next_state.irq_mask    = pwdata_in[IRQ_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state             <= '0;
			state.exec        <= ST_IDLE;
			state.result      <= RESULT_IDLE;
			state.rise_map    <= EVENT_MAP_RESET;
			state.fall_map    <= EVENT_MAP_RESET;
			state.capture_cfg <= CONFIG_RESET;
			state.cam_cfg     <= CONFIG_RESET;
			state.homing_cfg  <= CONFIG_RESET;
			state.irq_mask    <= IRQ_MASK_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign pready_out               = 1'b1;
	assign pslverr_out              = psel_in && penable_in && !addr_ok;
	assign prdata_out               = next_state.prdata;

	// ****************************************
	// Motion outputs
	// ****************************************
	assign launch_valid_out         = state.launch_valid;
	assign launch_path_out          = state.launch_path;
	assign stop_request_out         = state.stop_req;
	assign homing_active_out        = (state.exec == ST_HOMING) || (state.exec == ST_HOME_BRAKE);
	assign soft_limit_enable_out    = !homing_active_out; // RL11
	assign command_end_position_out = state.end_position;
	assign command_done_output_out  = state.cmd_done;
	assign homing_done_output_out   = state.home_done;

	// ****************************************
	// Interrupt output
	// ****************************************
	assign irq_out                  = |(state.irq_status & state.irq_mask);

endmodule

// *** dv/host_ctrl_model.sv ***
`timescale 1ns/100ps
module host_ctrl_model
	import path_trigger_pkg::*;
(
	input  wire logic              mclk_in,
	output logic      [PATH_W-1:0] path_select_out,
	output logic      [10:0]       pins_out
);
	initial begin
		path_select_out = 6'h00;
		pins_out = 11'h000;
	end

	// Path number settles before the strobe rises
	task select_path(input logic [5:0] p);
		@(posedge mclk_in);
		path_select_out <= p;
	endtask

	task set_pin(input int idx, input logic v);
		@(posedge mclk_in);
		pins_out[idx] <= v;
	endtask
endmodule

// *** dv/path_trigger_monitor.sv ***
`timescale 1ns/100ps
module path_trigger_monitor
	import path_trigger_pkg::*;
(
	input  wire logic              mclk_in,
	input  wire logic              rst_in,
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [7:0]        paddr_in,
	input  wire logic [31:0]       pwdata_in,
	input  wire logic              pslverr_out,
	input  wire logic              motion_stop_input_in,
	input  wire logic              homing_start_input_in,
	input  wire logic              launch_valid_out,
	input  wire logic [PATH_W-1:0] launch_path_out,
	input  wire logic              stop_request_out,
	input  wire logic              homing_active_out,
	input  wire logic              soft_limit_enable_out,
	input  wire logic [POS_W-1:0]  command_end_position_out,
	input  wire logic              command_done_output_out,
	input  wire logic              homing_done_output_out
);
	logic [31:0] idx_coord;
	logic [5:0]  sw_path;
	logic        wr_acc;

	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	assign wr_acc = psel_in && penable_in && pwrite_in;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			idx_coord <= 32'h0000_0000;
			sw_path <= 6'h00;
		end else begin
			if (wr_acc && paddr_in == INDEX_COORD_ADDR)
				idx_coord <= pwdata_in;
			if (wr_acc && paddr_in == SW_TRIGGER_ADDR)
				sw_path <= pwdata_in[5:0];
		end
	end

	property p_soft_limit;
		launch_valid_out && launch_path_out == HOMING_PATH && !homing_done_output_out
			|-> !soft_limit_enable_out;
	endproperty
	a_soft_limit: assert property (p_soft_limit)
		else $error("soft limit not suspended while homing");

	property p_stop_req;
		$rose(motion_stop_input_in) |-> ##[1:4] stop_request_out;
	endproperty
	a_stop_req: assert property (p_stop_req)
		else $error("stop edge gave no stop request");

	property p_stop_pulse;
		stop_request_out |=> !stop_request_out;
	endproperty
	a_stop_pulse: assert property (p_stop_pulse)
		else $error("stop request longer than one cycle");

	property p_home_launch;
		$rose(homing_start_input_in) && !motion_stop_input_in
			|-> ##[1:4] (launch_valid_out && launch_path_out == HOMING_PATH);
	endproperty
	a_home_launch: assert property (p_home_launch)
		else $error("homing input did not launch path 0");

	property p_path0_homes;
		launch_valid_out && launch_path_out == HOMING_PATH |-> ##[0:1] homing_active_out;
	endproperty
	a_path0_homes: assert property (p_path0_homes)
		else $error("path 0 launch did not start homing");

	property p_dones_clear;
		$rose(homing_active_out)
			|-> ##[0:1] (!command_done_output_out && !homing_done_output_out);
	endproperty
	a_dones_clear: assert property (p_dones_clear)
		else $error("done outputs not cleared at homing start");

	property p_dones_pair;
		$rose(homing_done_output_out) |-> command_done_output_out;
	endproperty
	a_dones_pair: assert property (p_dones_pair)
		else $error("homing done without command done");

	property p_end_pos;
		$rose(homing_done_output_out) |-> command_end_position_out == idx_coord;
	endproperty
	a_end_pos: assert property (p_end_pos)
		else $error("end position not the index coordinate");

	property p_sw_launch;
		wr_acc && paddr_in == SW_TRIGGER_ADDR && !motion_stop_input_in
			|-> ##[1:3] (launch_valid_out && launch_path_out == sw_path);
	endproperty
	a_sw_launch: assert property (p_sw_launch)
		else $error("software write did not launch its path");

	property p_slverr;
		psel_in && penable_in
			|-> pslverr_out == (paddr_in[1:0] != 2'h0 || paddr_in > STATE_ADDR);
	endproperty
	a_slverr: assert property (p_slverr)
		else $error("error response wrong for address");

	c_home: cover property ($rose(homing_done_output_out));
	c_stop: cover property (stop_request_out);
	c_capture: cover property (launch_valid_out && launch_path_out == CAPTURE_PATH);
endmodule

bind motion_path_trigger_select path_trigger_monitor path_trigger_monitor_i (
	.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
	.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
	.pslverr_out(pslverr_out), .motion_stop_input_in(motion_stop_input_in),
	.homing_start_input_in(homing_start_input_in), .launch_valid_out(launch_valid_out),
	.launch_path_out(launch_path_out), .stop_request_out(stop_request_out),
	.homing_active_out(homing_active_out), .soft_limit_enable_out(soft_limit_enable_out),
	.command_end_position_out(command_end_position_out),
	.command_done_output_out(command_done_output_out),
	.homing_done_output_out(homing_done_output_out));

// *** dv/tb_motion_path_trigger_select.sv ***
`timescale 1ns/100ps
module tb_motion_path_trigger_select;
	import path_trigger_pkg::*;
	localparam int STB = 0, HALT = 1, HOM = 2, EV = 3, CAP = 7, CAM = 8, IDX = 9, MC = 10;
	logic        mclk_in, rst_in, psel, penable, pwrite, rdy, err, lv, halt, hact, slim, cdone;
	logic        hdone, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, endpos, rd;
	logic [5:0]  psel_path, lpath;
	logic [10:0] pins;
	int          num_errors, checked, n;

	host_ctrl_model host_ctrl_model_i (.mclk_in(mclk_in), .path_select_out(psel_path),
		.pins_out(pins));
	motion_path_trigger_select motion_path_trigger_select_i (
		.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(rdy), .pslverr_out(err), .path_select_in(psel_path),
		.path_trigger_strobe_in(pins[STB]), .motion_stop_input_in(pins[HALT]),
		.homing_start_input_in(pins[HOM]), .event_inputs_in(pins[EV+3:EV]),
		.capture_done_in(pins[CAP]), .cam_disengage_in(pins[CAM]),
		.index_pulse_in(pins[IDX]), .motion_complete_in(pins[MC]),
		.launch_valid_out(lv), .launch_path_out(lpath), .stop_request_out(halt),
		.homing_active_out(hact), .soft_limit_enable_out(slim),
		.command_end_position_out(endpos), .command_done_output_out(cdone),
		.homing_done_output_out(hdone), .irq_out(irq));

	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end

	task finish_test();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_in);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge mclk_in);
			if (rdy === 1'b1)
				break;
		end
		if (n == 20) begin
			check("pready", 32'h1, 32'h0);
			finish_test();
		end
		rd = prdata;
		check("pslverr", {31'h0, a > STATE_ADDR}, {31'h0, err});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task expect_launch(input logic [5:0] p);
		for (n = 0; n < 10; n++) begin
			@(posedge mclk_in);
			if (lv === 1'b1)
				break;
		end
		if (n == 10) begin
			check("launch_valid", 32'h1, 32'h0);
			finish_test();
		end
		check("launch_path", {26'h0, p}, {26'h0, lpath});
	endtask

	task pin_launch(input int idx, input logic v, input logic [5:0] p);
		host_ctrl_model_i.set_pin(idx, v);
		expect_launch(p);
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata, num_errors, checked} = '0;
		rst_in = 1'b1;
		repeat (3) @(posedge mclk_in);
		rst_in <= 1'b0;
		apb(1'b0, EVENT_RISE_ADDR, 32'h0);
		check("rise_map", EVENT_MAP_RESET, rd);
		apb(1'b0, IRQ_MASK_ADDR, 32'h0);
		check("irq_mask", {28'h0, IRQ_MASK_RESET}, rd);
		apb(1'b0, 8'h30, 32'h0);
		check("unmapped", 32'h0, rd);
		check("soft_limit", 32'h1, {31'h0, slim});
		$display("registers done");
		for (int i = 0; i < 2; i++) begin
			host_ctrl_model_i.select_path(i ? 6'h3f : 6'h01);
			pin_launch(STB, 1'b1, i ? 6'h3f : 6'h01);
			host_ctrl_model_i.set_pin(STB, 1'b0);
		end
		check("irq_masked", 32'h0, {31'h0, irq});
		apb(1'b1, IRQ_MASK_ADDR, 32'h1);
		@(posedge mclk_in);
		check("irq_raised", 32'h1, {31'h0, irq});
		apb(1'b0, IRQ_STATUS_ADDR, 32'h0);
		check("irq_status", 32'h1, rd & 32'h1);
		@(posedge mclk_in);
		check("irq_cleared", 32'h0, {31'h0, irq});
		$display("strobe and irq done");
		apb(1'b1, EVENT_RISE_ADDR, 32'h0d0c0b0a);
		apb(1'b1, EVENT_FALL_ADDR, 32'h17161514);
		for (int i = 0; i < EVENT_COUNT; i++) begin
			pin_launch(EV + i, 1'b1, 6'h0a + 6'(i));
			pin_launch(EV + i, 1'b0, 6'h14 + 6'(i));
		end
		$display("events done");
		apb(1'b1, SW_TRIGGER_ADDR, 32'h5);
		expect_launch(6'h05);
		apb(1'b0, SW_TRIGGER_ADDR, 32'h0);
		check("result", {28'h0, RESULT_RUNNING}, (rd >> RESULT_LSB) & 32'hf);
		host_ctrl_model_i.set_pin(HALT, 1'b1);
		for (n = 0; n < 10 && halt !== 1'b1; n++)
			@(posedge mclk_in);
		check("stop_request", 32'h1, {31'h0, halt});
		apb(1'b0, SW_TRIGGER_ADDR, 32'h0);
		check("result", {28'h0, RESULT_STOPPED}, (rd >> RESULT_LSB) & 32'hf);
		host_ctrl_model_i.set_pin(HALT, 1'b0);
		apb(1'b1, SW_TRIGGER_ADDR, 32'h6);
		expect_launch(6'h06);
		host_ctrl_model_i.set_pin(MC, 1'b1);
		repeat (3) @(posedge mclk_in);
		apb(1'b0, SW_TRIGGER_ADDR, 32'h0);
		check("result", {28'h0, RESULT_DONE}, (rd >> RESULT_LSB) & 32'hf);
		host_ctrl_model_i.set_pin(MC, 1'b0);
		$display("software trigger done");
		apb(1'b1, CAPTURE_CFG_ADDR, 32'h0);
		host_ctrl_model_i.set_pin(CAP, 1'b1);
		for (n = 0; n < 8; n++) begin
			@(posedge mclk_in);
			if (lv === 1'b1)
				check("capture_off", 32'h0, 32'h1);
		end
		host_ctrl_model_i.set_pin(CAP, 1'b0);
		apb(1'b1, CAPTURE_CFG_ADDR, 32'h8);
		pin_launch(CAP, 1'b1, CAPTURE_PATH);
		host_ctrl_model_i.set_pin(CAP, 1'b0);
		apb(1'b1, CAM_CFG_ADDR, 32'h21);
		pin_launch(CAM, 1'b1, 6'h21);
		host_ctrl_model_i.set_pin(CAM, 1'b0);
		$display("capture and cam done");
		apb(1'b1, INDEX_COORD_ADDR, 32'h64);
		apb(1'b1, HOMING_CFG_ADDR, 32'h107);
		pin_launch(HOM, 1'b1, HOMING_PATH);
		@(posedge mclk_in);
		check("soft_limit", 32'h0, {31'h0, slim});
		check("homing_done", 32'h0, {31'h0, hdone});
		host_ctrl_model_i.set_pin(IDX, 1'b1);
		repeat (4) @(posedge mclk_in);
		pin_launch(MC, 1'b1, 6'h07);
		check("end_position", 32'h64, endpos);
		check("homing_done", 32'h1, {31'h0, hdone});
		check("command_done", 32'h1, {31'h0, cdone});
		host_ctrl_model_i.set_pin(MC, 1'b0);
		host_ctrl_model_i.set_pin(IDX, 1'b0);
		host_ctrl_model_i.set_pin(HOM, 1'b0);
		$display("homing done");
		finish_test();
	end
endmodule
